// ---- core/dsm_monitor.sv ----
// drive status monitor: display selection, alarm history, ratios, no-rotation cause
`timescale 1ns/1ps
//
// Overview of operation
// R1: after reset the display shows the item chosen by default_display_select.
// R2: control mode output reports position or speed; reserved codes flagged.
// R3: operator key toggles input/output view only when the point sits on I/O.
// R4: history keeps the fourteen most recent alarms including the current one.
// R5: any alarm occurrence makes the alarm display flash.
// R6: a recorded new alarm puts the same code in current and entry 0.
// R7: safety input error 30.0 flashes a distinct safety indication.
// R8: alarm causes are carried as two-digit main codes in bcd.
// R9: alarms 11, 13, 36, 37, 38 and 95 never enter history.
// R10: regeneration load shown as percent, overload detection level is 100.
// R11: overload shown as percent, rated load is 100.
// R12: no-rotation shows mode letter and cause; flashes on alarm or warning.
// R13: cause 0 when nothing blocks rotation.
// R14: cause 1 without main power, cause 2 without run command.
// R15: cause 3 when prohibition enabled and matching direction input open.
// R16: cause 4 when active torque limit is five percent or less.
// R17: position mode cause 6 when pulse prohibit open and its setting 0.
// R18: position mode cause 7 when pulses per cycle are one or fewer.
// R19: position mode cause 8 when counter clear asserted with condition 0.
// R20: cause 9 outside position mode when zero-speed open and select 1.
// R21: speed mode cause 11 when internal speed command is 30 r/min or less.
// R22: cause 14 when nothing else applies yet speed is 20 r/min or less.
// R23: each recorded alarm shifts history older, dropping the oldest when full.
module dsm_monitor #(
    parameter int HIST_DEPTH = dsm_pkg::HIST_DEPTH,
    parameter int FLASH_CYCLES = dsm_pkg::FLASH_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] default_display_select,
    input wire logic item_next,
    input wire logic point_on_io,
    input wire logic io_toggle,
    input wire logic [1:0] ctrl_mode,
    input wire logic alarm_event,
    input wire logic [7:0] alarm_code_in,
    input wire logic warning_active,
    input wire logic alarm_clear,
    input wire logic [3:0] hist_index,
    input wire logic [15:0] regen_load,
    input wire logic [15:0] regen_detect_level,
    input wire logic [15:0] motor_load,
    input wire logic [15:0] rated_load,
    input wire logic main_power_on,
    input wire logic run_input,
    input wire logic drive_prohibit_enable_setting,
    input wire logic forward_prohibit_input,
    input wire logic reverse_prohibit_input,
    input wire logic speed_cmd_forward,
    input wire logic speed_cmd_reverse,
    input wire logic second_limit_select,
    input wire logic [15:0] first_torque_limit,
    input wire logic [15:0] second_torque_limit,
    input wire logic pulse_prohibit_input,
    input wire logic pulse_prohibit_setting,
    input wire logic [15:0] pulses_per_cycle,
    input wire logic error_counter_clear_input,
    input wire logic counter_clear_condition,
    input wire logic zero_speed_input,
    input wire logic zero_speed_select,
    input wire logic [15:0] internal_speed_cmd,
    input wire logic [15:0] motor_speed_abs,
    output logic [3:0] display_item,
    output logic io_show_outputs,
    output logic mode_is_position,
    output logic mode_is_speed,
    output logic mode_reserved,
    output logic [7:0] current_alarm,
    output logic alarm_active,
    output logic [7:0] hist_code,
    output logic [3:0] hist_count,
    output logic alarm_flash,
    output logic safety_flash,
    output logic [15:0] regen_pct,
    output logic [15:0] overload_pct,
    output logic [7:0] no_rot_letter,
    output logic [3:0] no_rot_cause,
    output logic no_rot_flash,
    output logic blink_phase
);
    ////////////////////////////////////////////////////////////////////////////
    // display item selection
    logic [3:0] item_reg;
    logic [3:0] item_next_val;
    logic default_pending_reg;
    wire [3:0] item_wrap = (item_reg == 4'(dsm_pkg::DSM_ITEM_NO_ROT)) ?
        4'(dsm_pkg::DSM_ITEM_SPEED) : item_reg + 4'h1;
    assign item_next_val = default_pending_reg ? default_display_select :
        (item_next ? item_wrap : item_reg);

    // default taken in the first clocked cycle after release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            item_reg <= dsm_pkg::DEFAULT_DISPLAY_RESET;
            default_pending_reg <= 1'b1;
        end else begin
            item_reg <= item_next_val; // see R1
            default_pending_reg <= 1'b0;
        end
    end
    assign display_item = item_reg;

    ////////////////////////////////////////////////////////////////////////////
    // i/o view toggle
    logic io_out_reg;
    wire io_toggle_ok = io_toggle && point_on_io &&
        (item_reg == 4'(dsm_pkg::DSM_ITEM_IO));
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            io_out_reg <= 1'b0;
        end else if (io_toggle_ok) begin
            io_out_reg <= !io_out_reg; // see R3
        end
    end
    assign io_show_outputs = io_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // control mode indication
    logic [1:0] mode_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= dsm_pkg::MODE_POSITION;
        end else begin
            mode_reg <= ctrl_mode;
        end
    end
    assign mode_is_position = (mode_reg == dsm_pkg::MODE_POSITION); // see R2
    assign mode_is_speed = (mode_reg == dsm_pkg::MODE_SPEED); // see R2
    assign mode_reserved = (mode_reg == dsm_pkg::MODE_RSVD_A) ||
        (mode_reg == dsm_pkg::MODE_RSVD_B);

    ////////////////////////////////////////////////////////////////////////////
    // alarm history
    logic [7:0] hist_mem [HIST_DEPTH];
    logic [7:0] cur_reg;
    logic active_reg;
    logic [3:0] count_reg;
    // excluded codes stay out of the history
    wire recordable = !(alarm_code_in == dsm_pkg::ALM_CTRL_UV ||
        alarm_code_in == dsm_pkg::ALM_MAIN_UV ||
        alarm_code_in == dsm_pkg::ALM_PARAM_ERR ||
        alarm_code_in == dsm_pkg::ALM_PARAM_DESTR ||
        alarm_code_in == dsm_pkg::ALM_PROHIBIT ||
        alarm_code_in == dsm_pkg::ALM_MOTOR_MISMATCH); // see R9
    wire record = alarm_event && recordable;
    wire [3:0] count_inc = (count_reg == 4'(HIST_DEPTH)) ? count_reg : count_reg + 4'h1;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur_reg <= dsm_pkg::ALM_NONE;
            active_reg <= 1'b0;
        end else if (alarm_event) begin
            cur_reg <= alarm_code_in; // see R8
            active_reg <= 1'b1;
        end else if (alarm_clear) begin
            active_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 4'h0;
        end else if (record) begin
            count_reg <= count_inc; // see R4
        end
    end

    generate
        for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    hist_mem[i] <= dsm_pkg::ALM_NONE;
                end else if (record) begin
                    if (i == 0) begin
                        hist_mem[i] <= alarm_code_in; // see R6
                    end else begin
                        hist_mem[i] <= hist_mem[i-1]; // see R23
                    end
                end
            end
        end
    endgenerate

    wire hist_idx_ok = (int'(hist_index) < HIST_DEPTH);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hist_code <= dsm_pkg::ALM_NONE;
        end else begin
            hist_code <= hist_idx_ok ? hist_mem[hist_index] : dsm_pkg::ALM_NONE;
        end
    end
    assign current_alarm = cur_reg;
    assign alarm_active = active_reg;
    assign hist_count = count_reg;

    ////////////////////////////////////////////////////////////////////////////
    // flash timebase
    logic [31:0] flash_cnt_reg;
    logic blink_reg;
    wire flash_tick = (flash_cnt_reg == 32'(FLASH_CYCLES - 1));
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flash_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
        end else if (flash_tick) begin
            flash_cnt_reg <= 32'h0000_0000;
            blink_reg <= !blink_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
        end
    end
    assign blink_phase = blink_reg;
    assign alarm_flash = active_reg; // see R5
    assign safety_flash = active_reg && (cur_reg == dsm_pkg::ALM_SAFETY); // see R7

    ////////////////////////////////////////////////////////////////////////////
    // load ratios
    function automatic logic [15:0] pct_of(input logic [15:0] val, input logic [15:0] full);
        logic [31:0] prod;
        prod = 32'(val) * 32'(dsm_pkg::PCT_FULL);
        if (full == 16'h0000) begin
            return 16'h0000;
        end
        return 16'(prod / 32'(full));
    endfunction

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regen_pct <= 16'h0000;
            overload_pct <= 16'h0000;
        end else begin
            regen_pct <= pct_of(regen_load, regen_detect_level); // see R10
            overload_pct <= pct_of(motor_load, rated_load); // see R11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // no-rotation cause
    logic [3:0] cause_w;
    dsm_no_rotation u_no_rot (
        .ctrl_mode(ctrl_mode),
        .main_power_on(main_power_on),
        .run_input(run_input),
        .drive_prohibit_enable_setting(drive_prohibit_enable_setting),
        .forward_prohibit_input(forward_prohibit_input),
        .reverse_prohibit_input(reverse_prohibit_input),
        .speed_cmd_forward(speed_cmd_forward),
        .speed_cmd_reverse(speed_cmd_reverse),
        .second_limit_select(second_limit_select),
        .first_torque_limit(first_torque_limit),
        .second_torque_limit(second_torque_limit),
        .pulse_prohibit_input(pulse_prohibit_input),
        .pulse_prohibit_setting(pulse_prohibit_setting),
        .pulses_per_cycle(pulses_per_cycle),
        .error_counter_clear_input(error_counter_clear_input),
        .counter_clear_condition(counter_clear_condition),
        .zero_speed_input(zero_speed_input),
        .zero_speed_select(zero_speed_select),
        .internal_speed_cmd(internal_speed_cmd),
        .motor_speed_abs(motor_speed_abs),
        .cause(cause_w)
    );
    wire [7:0] letter_w = (ctrl_mode == dsm_pkg::MODE_POSITION) ? dsm_pkg::LETTER_POS :
        (ctrl_mode == dsm_pkg::MODE_SPEED) ? dsm_pkg::LETTER_SPD : dsm_pkg::LETTER_RSVD;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            no_rot_cause <= dsm_pkg::CAUSE_NONE;
            no_rot_letter <= dsm_pkg::LETTER_POS;
        end else begin
            no_rot_cause <= cause_w; // see R12
            no_rot_letter <= letter_w; // see R12
        end
    end
    assign no_rot_flash = active_reg || warning_active; // see R12

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_default_item: assert property (@(posedge clock) disable iff (!nrst)
        default_pending_reg |=> (item_reg == $past(default_display_select))) // see R1
        else $error("default display item not taken after reset");
    a_io_toggle_gate: assert property (@(posedge clock) disable iff (!nrst)
        (io_toggle && !point_on_io) |=> $stable(io_out_reg)) // see R3
        else $error("i/o view toggled with point elsewhere");
    a_hist_zero: assert property (@(posedge clock) disable iff (!nrst)
        record |=> (hist_mem[0] == cur_reg)) // see R6
        else $error("history entry 0 differs from current alarm");
    a_hist_excluded: assert property (@(posedge clock) disable iff (!nrst)
        (alarm_event && !recordable) |=> $stable(count_reg)) // see R9
        else $error("excluded alarm entered history");
    a_hist_shift: assert property (@(posedge clock) disable iff (!nrst)
        record |=> (hist_mem[1] == $past(hist_mem[0]))) // see R23
        else $error("history did not shift");
    a_hist_bound: assert property (@(posedge clock) disable iff (!nrst)
        count_reg <= 4'(HIST_DEPTH)) // see R4
        else $error("history count exceeds depth");
    a_alarm_flash: assert property (@(posedge clock) disable iff (!nrst)
        alarm_event |=> alarm_flash && no_rot_flash) // see R5
        else $error("alarm did not start flashing");
    a_safety_flash: assert property (@(posedge clock) disable iff (!nrst)
        (alarm_event && alarm_code_in == dsm_pkg::ALM_SAFETY) |=> safety_flash) // see R7
        else $error("safety indication missing");
    a_cause_power: assert property (@(posedge clock) disable iff (!nrst)
        !main_power_on |=> (no_rot_cause == dsm_pkg::CAUSE_MAIN_OFF)) // see R14
        else $error("cause 1 not reported without main power");
    a_regen_full: assert property (@(posedge clock) disable iff (!nrst)
        (regen_load == regen_detect_level && regen_load != 16'h0000)
        |=> (regen_pct == dsm_pkg::PCT_FULL)) // see R10
        else $error("regeneration at detection level not 100 percent");
endmodule

// ---- core/dsm_no_rotation.sv ----
// cause encoder for the motor no-rotation monitor
`timescale 1ns/1ps
module dsm_no_rotation (
    input wire logic [1:0] ctrl_mode,
    input wire logic main_power_on,
    input wire logic run_input,
    input wire logic drive_prohibit_enable_setting,
    input wire logic forward_prohibit_input,
    input wire logic reverse_prohibit_input,
    input wire logic speed_cmd_forward,
    input wire logic speed_cmd_reverse,
    input wire logic second_limit_select,
    input wire logic [15:0] first_torque_limit,
    input wire logic [15:0] second_torque_limit,
    input wire logic pulse_prohibit_input,
    input wire logic pulse_prohibit_setting,
    input wire logic [15:0] pulses_per_cycle,
    input wire logic error_counter_clear_input,
    input wire logic counter_clear_condition,
    input wire logic zero_speed_input,
    input wire logic zero_speed_select,
    input wire logic [15:0] internal_speed_cmd,
    input wire logic [15:0] motor_speed_abs,
    output logic [3:0] cause
);
    wire is_pos = (ctrl_mode == dsm_pkg::MODE_POSITION);
    wire is_spd = (ctrl_mode == dsm_pkg::MODE_SPEED);
    // prohibit inputs are true when the contact is open
    wire c_prohibit = !drive_prohibit_enable_setting &&
        ((forward_prohibit_input && speed_cmd_forward) ||
         (reverse_prohibit_input && speed_cmd_reverse));
    wire [15:0] active_limit = second_limit_select ? second_torque_limit : first_torque_limit;
    wire c_torque = (active_limit <= dsm_pkg::TORQUE_MIN_PCT);
    wire c_pulse_inh = is_pos && pulse_prohibit_input && !pulse_prohibit_setting;
    wire c_pulse_low = is_pos && (pulses_per_cycle <= dsm_pkg::PULSE_MIN);
    wire c_clear = is_pos && error_counter_clear_input && !counter_clear_condition;
    wire c_zero = !is_pos && zero_speed_input && zero_speed_select;
    wire c_int_spd = is_spd && (internal_speed_cmd <= dsm_pkg::INT_SPEED_MIN_RPM);
    wire c_other = (motor_speed_abs <= dsm_pkg::ROT_MIN_RPM);

    // lowest numbered cause wins
    always_comb begin
        if (!main_power_on) begin
            cause = dsm_pkg::CAUSE_MAIN_OFF; // see R14
        end else if (!run_input) begin
            cause = dsm_pkg::CAUSE_NO_RUN; // see R14
        end else if (c_prohibit) begin
            cause = dsm_pkg::CAUSE_PROHIBIT; // see R15
        end else if (c_torque) begin
            cause = dsm_pkg::CAUSE_TORQUE; // see R16
        end else if (c_pulse_inh) begin
            cause = dsm_pkg::CAUSE_PULSE_INH; // see R17
        end else if (c_pulse_low) begin
            cause = dsm_pkg::CAUSE_PULSE_LOW; // see R18
        end else if (c_clear) begin
            cause = dsm_pkg::CAUSE_CLEAR; // see R19
        end else if (c_zero) begin
            cause = dsm_pkg::CAUSE_ZERO_SPD; // see R20
        end else if (c_int_spd) begin
            cause = dsm_pkg::CAUSE_INT_SPEED; // see R21
        end else if (c_other) begin
            cause = dsm_pkg::CAUSE_OTHER; // see R22
        end else begin
            cause = dsm_pkg::CAUSE_NONE; // see R13
        end
    end
endmodule

// ---- core/dsm_pkg.sv ----
// constants, types and encodings for the drive status monitor
package dsm_pkg;
    localparam int HIST_DEPTH = 14;
    localparam int CODE_W = 8;
    localparam int CAUSE_W = 4;
    localparam int PCT_W = 16;
    localparam int SPEED_W = 16;

    // display items selectable by the operator or as default
    typedef enum logic [3:0] {
        DSM_ITEM_SPEED = 4'h0,
        DSM_ITEM_CTRL_MODE = 4'h1,
        DSM_ITEM_IO = 4'h2,
        DSM_ITEM_ALARM = 4'h3,
        DSM_ITEM_REGEN = 4'h4,
        DSM_ITEM_OVERLOAD = 4'h5,
        DSM_ITEM_NO_ROT = 4'h6
    } dsm_item_e;
    localparam logic [3:0] DEFAULT_DISPLAY_RESET = 4'h0;

    // control mode codes; two reserved codes must not be selected
    localparam logic [1:0] MODE_POSITION = 2'h0;
    localparam logic [1:0] MODE_SPEED = 2'h1;
    localparam logic [1:0] MODE_RSVD_A = 2'h2;
    localparam logic [1:0] MODE_RSVD_B = 2'h3;

    // display letters of the control mode prefix (ascii)
    localparam logic [7:0] LETTER_POS = 8'h50;
    localparam logic [7:0] LETTER_SPD = 8'h53;
    localparam logic [7:0] LETTER_RSVD = 8'h2D;

    // alarm main codes (two decimal digits, held as bcd)
    localparam logic [7:0] ALM_NONE = 8'h00;
    localparam logic [7:0] ALM_CTRL_UV = 8'h11;
    localparam logic [7:0] ALM_MAIN_UV = 8'h13;
    localparam logic [7:0] ALM_ENC_DATA = 8'h23;
    localparam logic [7:0] ALM_OVERSPEED = 8'h26;
    localparam logic [7:0] ALM_SAFETY = 8'h30;
    localparam logic [7:0] ALM_PARAM_ERR = 8'h36;
    localparam logic [7:0] ALM_PARAM_DESTR = 8'h37;
    localparam logic [7:0] ALM_PROHIBIT = 8'h38;
    localparam logic [7:0] ALM_ENC_CS = 8'h49;
    localparam logic [7:0] ALM_MOTOR_MISMATCH = 8'h95;

    // no-rotation cause numbers
    localparam logic [3:0] CAUSE_NONE = 4'h0;
    localparam logic [3:0] CAUSE_MAIN_OFF = 4'h1;
    localparam logic [3:0] CAUSE_NO_RUN = 4'h2;
    localparam logic [3:0] CAUSE_PROHIBIT = 4'h3;
    localparam logic [3:0] CAUSE_TORQUE = 4'h4;
    localparam logic [3:0] CAUSE_PULSE_INH = 4'h6;
    localparam logic [3:0] CAUSE_PULSE_LOW = 4'h7;
    localparam logic [3:0] CAUSE_CLEAR = 4'h8;
    localparam logic [3:0] CAUSE_ZERO_SPD = 4'h9;
    localparam logic [3:0] CAUSE_INT_SPEED = 4'hB;
    localparam logic [3:0] CAUSE_OTHER = 4'hE;

    // thresholds
    localparam logic [15:0] TORQUE_MIN_PCT = 16'h0005;
    localparam logic [15:0] PULSE_MIN = 16'h0001;
    localparam logic [15:0] INT_SPEED_MIN_RPM = 16'h001E;
    localparam logic [15:0] ROT_MIN_RPM = 16'h0014;
    localparam logic [15:0] PCT_FULL = 16'h0064;

    // flash divider: 100 MHz clock, 250 ms half period
    localparam int CLK_HZ = 100_000_000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;
endpackage

// ---- verification/dsm_panel_op.sv ----
// front panel key operator model for the drive status monitor
`timescale 1ns/1ps
module dsm_panel_op (
    input wire logic clock,
    output logic item_next,
    output logic io_toggle,
    output logic point_on_io
);
    initial begin
        item_next = 1'b0;
        io_toggle = 1'b0;
        point_on_io = 1'b0;
    end
    // one-cycle key press launched just after a rising edge
    task automatic press(input logic toggle_key);
        @(posedge clock);
        if (toggle_key) begin
            io_toggle <= 1'b1;
        end else begin
            item_next <= 1'b1;
        end
        @(posedge clock);
        io_toggle <= 1'b0;
        item_next <= 1'b0;
    endtask
    task automatic move_point(input logic on_io);
        @(posedge clock);
        point_on_io <= on_io;
    endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the drive status monitor
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0, nrst = 1'b0, alarm_event = 1'b0, alarm_clear = 1'b0, warning_active;
    logic [3:0] default_display_select, hist_index = 4'h0;
    logic [1:0] ctrl_mode;
    logic [7:0] alarm_code_in = 8'h00;
    logic [15:0] regen_load = 16'h0000, regen_detect_level = 16'h0064;
    logic [15:0] motor_load = 16'h0000, rated_load = 16'h0064;
    logic main_power_on, run_input, drive_prohibit_enable_setting, forward_prohibit_input;
    logic reverse_prohibit_input, speed_cmd_forward, speed_cmd_reverse, second_limit_select;
    logic pulse_prohibit_input, pulse_prohibit_setting, error_counter_clear_input;
    logic counter_clear_condition, zero_speed_input, zero_speed_select;
    logic [15:0] first_torque_limit, second_torque_limit, pulses_per_cycle;
    logic [15:0] internal_speed_cmd, motor_speed_abs, regen_pct, overload_pct;
    logic item_next, point_on_io, io_toggle, io_show_outputs, mode_is_position, mode_is_speed;
    logic mode_reserved, alarm_active, alarm_flash, safety_flash, no_rot_flash, blink_phase;
    logic [3:0] display_item, hist_count, no_rot_cause;
    logic [7:0] current_alarm, hist_code, no_rot_letter;
    int n_mismatch = 0, total_checks = 0, cycles = 0;

    dsm_monitor #(.FLASH_CYCLES(4)) u_dut (.*);
    dsm_panel_op u_panel (.*);

    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // quiet operating point: nothing blocks rotation
    task automatic base;
        {main_power_on, run_input, drive_prohibit_enable_setting} <= 3'h7;
        {forward_prohibit_input, reverse_prohibit_input, speed_cmd_forward} <= 3'h0;
        {speed_cmd_reverse, second_limit_select, pulse_prohibit_input} <= 3'h0;
        {pulse_prohibit_setting, error_counter_clear_input, counter_clear_condition} <= 3'h5;
        {zero_speed_input, zero_speed_select, warning_active} <= 3'h0;
        {first_torque_limit, second_torque_limit} <= {16'h0064, 16'h0064};
        {internal_speed_cmd, motor_speed_abs, pulses_per_cycle} <= {16'h0064, 16'h0064, 16'h000A};
        ctrl_mode <= 2'h0;
    endtask
    task automatic fresh;
        @(posedge clock);
        base();
        @(posedge clock);
    endtask
    task automatic cause_is(input logic [3:0] e);
        repeat (2) @(posedge clock);
        #1;
        check("no_rot_cause", no_rot_cause, e);
    endtask
    task automatic fire(input logic [7:0] c);
        @(posedge clock);
        alarm_event <= 1'b1;
        alarm_code_in <= c;
        @(posedge clock);
        alarm_event <= 1'b0;
        #1;
    endtask
    task automatic hist(input logic [3:0] i, input logic [7:0] e);
        @(posedge clock);
        hist_index <= i;
        repeat (2) @(posedge clock);
        #1;
        check("hist_code", hist_code, e);
    endtask
    task automatic rst(input logic [3:0] d);
        @(posedge clock);
        {nrst, default_display_select} <= {1'b0, d};
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
        check("display_item", display_item, d);
        check("hist_reset", hist_count, 4'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_panel;
        u_panel.press(1'b1);
        #1;
        check("io_refused", io_show_outputs, 1'b0);
        u_panel.move_point(1'b1);
        u_panel.press(1'b1);
        #1;
        check("io_toggled", io_show_outputs, 1'b1);
        repeat (5) u_panel.press(1'b0);
        u_panel.press(1'b1);
        #1;
        check("item_wrap", display_item, 4'h0);
        check("io_off_item", io_show_outputs, 1'b1);
    endtask
    task automatic t_mode;
        for (int m = 0; m < 4; m++) begin
            @(posedge clock);
            ctrl_mode <= m[1:0];
            repeat (2) @(posedge clock);
            #1;
            check("mode_pos", mode_is_position, m == 0);
            check("mode_spd", mode_is_speed, m == 1);
            check("mode_rsvd", mode_reserved, m > 1);
        end
    endtask
    task automatic t_alarm;
        logic [7:0] skip[6] = '{8'h11, 8'h13, 8'h36, 8'h37, 8'h38, 8'h95};
        fire(8'h26);
        check("current", current_alarm, 8'h26);
        check("flash", alarm_flash, 1'b1);
        check("safety_off", safety_flash, 1'b0);
        hist(4'h0, 8'h26);
        foreach (skip[k]) begin
            fire(skip[k]);
            check("cur_skip", current_alarm, skip[k]);
            check("cnt_skip", hist_count, 4'h1);
        end
        hist(4'h0, 8'h26);
        fire(8'h30);
        check("safety_on", safety_flash, 1'b1);
        repeat (12) fire(8'h12);
        check("cnt_full", hist_count, 4'hE);
        hist(4'hD, 8'h26);
        fire(8'h16);
        check("cnt_sat", hist_count, 4'hE);
        hist(4'hD, 8'h30);
        hist(4'h0, 8'h16);
        @(posedge clock);
        alarm_clear <= 1'b1;
        @(posedge clock);
        alarm_clear <= 1'b0;
        #1;
        check("flash_clr", alarm_flash, 1'b0);
        check("active_clr", alarm_active, 1'b0);
    endtask
    task automatic t_ratio;
        logic b;
        @(posedge clock);
        {regen_load, regen_detect_level} <= {16'h00C8, 16'h00C8};
        {motor_load, rated_load} <= {16'h0096, 16'h00C8};
        repeat (2) @(posedge clock);
        #1;
        check("regen_pct", regen_pct, 16'h0064);
        check("overload_pct", overload_pct, 16'h004B);
        b = blink_phase;
        repeat (4) @(posedge clock);
        #1;
        check("blink", blink_phase, !b);
    endtask
    task automatic t_cause;
        fresh();
        cause_is(4'h0);
        check("letter_p", no_rot_letter, 8'h50);
        fresh();
        main_power_on <= 1'b0;
        cause_is(4'h1);
        fresh();
        run_input <= 1'b0;
        cause_is(4'h2);
        fresh();
        {drive_prohibit_enable_setting, forward_prohibit_input, speed_cmd_forward} <= 3'h3;
        cause_is(4'h3);
        fresh();
        {drive_prohibit_enable_setting, reverse_prohibit_input, speed_cmd_reverse} <= 3'h3;
        cause_is(4'h3);
        fresh();
        {drive_prohibit_enable_setting, forward_prohibit_input, speed_cmd_reverse} <= 3'h3;
        cause_is(4'h0);
        fresh();
        {second_limit_select, second_torque_limit} <= {1'b1, 16'h0005};
        cause_is(4'h4);
        fresh();
        {second_limit_select, first_torque_limit} <= {1'b1, 16'h0005};
        cause_is(4'h0);
        fresh();
        {pulse_prohibit_input, pulse_prohibit_setting} <= 2'h2;
        cause_is(4'h6);
        fresh();
        pulses_per_cycle <= 16'h0001;
        cause_is(4'h7);
        fresh();
        {error_counter_clear_input, counter_clear_condition} <= 2'h2;
        cause_is(4'h8);
        fresh();
        {ctrl_mode, zero_speed_input, zero_speed_select} <= 4'h7;
        cause_is(4'h9);
        check("letter_s", no_rot_letter, 8'h53);
        fresh();
        {ctrl_mode, internal_speed_cmd} <= {2'h1, 16'h001E};
        cause_is(4'hB);
        fresh();
        {ctrl_mode, pulses_per_cycle} <= {2'h1, 16'h0001};
        cause_is(4'h0);
        fresh();
        motor_speed_abs <= 16'h0014;
        cause_is(4'hE);
        fresh();
        warning_active <= 1'b1;
        cause_is(4'h0);
        check("no_rot_flash", no_rot_flash, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        base();
        rst(4'h2);
        t_panel();
        t_mode();
        t_alarm();
        t_ratio();
        rst(4'h6);
        t_cause();
        results();
    end
endmodule
